// file: dmp_pkg.sv
// Constants shared by the dual-modulus divider core
package dmp_pkg;
    // ----------------------------------------------------------------
    // Latch widths
    // ----------------------------------------------------------------
    localparam int AUX_W  = 7;
    localparam int MAIN_W = 10;
    localparam int REF_W  = 12;
    localparam int NIB_W  = 4;
    localparam int SEL_W  = 3;

    // ----------------------------------------------------------------
    // Latch select codes
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_AUX_LOW  = 3'h0;
    localparam logic [SEL_W-1:0] SEL_AUX_HIGH = 3'h1;
    localparam logic [SEL_W-1:0] SEL_MAIN_LOW = 3'h2;
    localparam logic [SEL_W-1:0] SEL_MAIN_MID = 3'h3;
    localparam logic [SEL_W-1:0] SEL_MAIN_HI  = 3'h4;
    localparam logic [SEL_W-1:0] SEL_REF_LOW  = 3'h5;
    localparam logic [SEL_W-1:0] SEL_REF_MID  = 3'h6;
    localparam logic [SEL_W-1:0] SEL_REF_HI   = 3'h7;

    // ----------------------------------------------------------------
    // Field positions inside the assembled counts
    // ----------------------------------------------------------------
    localparam int POS_LOW      = 0;
    localparam int POS_MID      = 4;
    localparam int POS_HIGH     = 8;
    localparam int AUX_HIGH_W   = 3;
    localparam int MAIN_HIGH_W  = 2;

    // ----------------------------------------------------------------
    // Phase detector minimum coincidence pulse
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PFD_MIN_NS    = 20;
    localparam int PFD_MIN_CYC   = (PFD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PFD_CNT_W     = 4;
endpackage

// file: dmp_core.sv
// Dual-modulus divider core: latches, dividers, phase detector, lock
`timescale 1ns/1ps

module dmp_core
    import dmp_pkg::*;
#(
    parameter int MIN_JOINT_CYC = PFD_MIN_CYC
)
(
    input  wire logic             CLOCK,
    input  wire logic             SRST,
    input  wire logic [NIB_W-1:0] BUS_NIBBLE,
    input  wire logic [SEL_W-1:0] LATCH_SELECT,
    input  wire logic             LOAD_STROBE,
    input  wire logic             REF_OSC_IN,
    input  wire logic             VCO_FEEDBACK_IN,
    output logic                  PRESCALER_RATIO_SELECT,
    output logic                  FEEDBACK_DIVIDED_OUT,
    output logic                  REF_DIVIDED_OUT,
    output logic                  TRISTATE_ERROR_OUT,
    output logic                  TRISTATE_ERROR_OE_N,
    output logic                  FEEDBACK_LEAD_PULSE_N,
    output logic                  REF_LEAD_PULSE_N,
    output logic                  LOCK_INDICATOR
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NIB_W-1:0]     nib_s1;
        logic [NIB_W-1:0]     nib_s2;
        logic [SEL_W-1:0]     sel_s1;
        logic [SEL_W-1:0]     sel_s2;
        logic                 stb_s1;
        logic                 stb_s2;
        logic                 ref_s1;
        logic                 ref_s2;
        logic                 ref_s3;
        logic                 vco_s1;
        logic                 vco_s2;
        logic                 vco_s3;
        logic [AUX_W-1:0]     aux_count;
        logic [MAIN_W-1:0]    main_count;
        logic [REF_W-1:0]     ref_div;
        logic [AUX_W-1:0]     aux_cnt;
        logic [MAIN_W-1:0]    main_cnt;
        logic [REF_W-1:0]     ref_cnt;
        logic                 ratio_sel;
        logic                 fb_div;
        logic                 ref_divd;
        logic                 up;
        logic                 dn;
        logic [PFD_CNT_W-1:0] clr_cnt;
        logic                 pd_out;
        logic                 pd_oe_n;
        logic                 fb_lead_n;
        logic                 ref_lead_n;
        logic                 lock;
    } dmp_state_t;

    dmp_state_t state;
    dmp_state_t next_state;

    // Edge pulses and terminal-count events, one cycle each
    logic ref_edge;
    logic vco_edge;
    logic fb_evt;
    logic ref_evt;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (MIN_JOINT_CYC < 1 || MIN_JOINT_CYC >= (1 << PFD_CNT_W))
    begin : g_bad_joint
        $error("joint pulse length does not fit its counter");
    end
    if (AUX_W != POS_MID + AUX_HIGH_W || MAIN_W != POS_HIGH + MAIN_HIGH_W)
    begin : g_bad_count
        $error("counter widths disagree with latch fields");
    end
    if (REF_W != POS_HIGH + NIB_W || NIB_W < MAIN_HIGH_W || NIB_W < AUX_HIGH_W)
    begin : g_bad_ref
        $error("reference width disagrees with latch fields");
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        fb_evt     = 1'b0;
        ref_evt    = 1'b0;

        // Two-stage synchronisers, third stage for edge detection
        next_state.nib_s1 = BUS_NIBBLE;
        next_state.nib_s2 = state.nib_s1;
        next_state.sel_s1 = LATCH_SELECT;
        next_state.sel_s2 = state.sel_s1;
        next_state.stb_s1 = LOAD_STROBE;
        next_state.stb_s2 = state.stb_s1;
        next_state.ref_s1 = REF_OSC_IN;
        next_state.ref_s2 = state.ref_s1;
        next_state.ref_s3 = state.ref_s2;
        next_state.vco_s1 = VCO_FEEDBACK_IN;
        next_state.vco_s2 = state.vco_s1;
        next_state.vco_s3 = state.vco_s2;
        ref_edge = state.ref_s2 && !state.ref_s3;
        vco_edge = state.vco_s2 && !state.vco_s3;

        // ------------------------------------------------------------
        // Latch bank: transparent while strobe high, holds when low
        // ------------------------------------------------------------
        if (state.stb_s2)
        begin
            // Unused high bits of latches 1 and 4 are dropped
            unique case (state.sel_s2)
                SEL_AUX_LOW:
                begin
                    next_state.aux_count[POS_LOW +: NIB_W] = state.nib_s2;
                end
                SEL_AUX_HIGH:
                begin
                    next_state.aux_count[POS_MID +: AUX_HIGH_W] =
                        state.nib_s2[AUX_HIGH_W-1:0];
                end
                SEL_MAIN_LOW:
                begin
                    next_state.main_count[POS_LOW +: NIB_W] = state.nib_s2;
                end
                SEL_MAIN_MID:
                begin
                    next_state.main_count[POS_MID +: NIB_W] = state.nib_s2;
                end
                SEL_MAIN_HI:
                begin
                    next_state.main_count[POS_HIGH +: MAIN_HIGH_W] =
                        state.nib_s2[MAIN_HIGH_W-1:0];
                end
                SEL_REF_LOW:
                begin
                    next_state.ref_div[POS_LOW +: NIB_W] = state.nib_s2;
                end
                SEL_REF_MID:
                begin
                    next_state.ref_div[POS_MID +: NIB_W] = state.nib_s2;
                end
                SEL_REF_HI:
                begin
                    next_state.ref_div[POS_HIGH +: NIB_W] = state.nib_s2;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Main and aux counters on feedback edges
        // ------------------------------------------------------------
        if (vco_edge)
        begin
            next_state.fb_div = 1'b0;
            // Terminal count: reload both counters and restart the cycle
            if (state.main_cnt <= MAIN_W'(1))
            begin
                next_state.main_cnt  = state.main_count;
                next_state.aux_cnt   = state.aux_count;
                next_state.ratio_sel = (state.aux_count == '0);
                next_state.fb_div    = 1'b1;
                fb_evt               = 1'b1;
            end
            else
            begin
                next_state.main_cnt = state.main_cnt - MAIN_W'(1);
                if (state.aux_cnt != '0)
                begin
                    next_state.aux_cnt = state.aux_cnt - AUX_W'(1);
                    // Aux expiry moves the prescaler to its lower ratio
                    if (state.aux_cnt == AUX_W'(1))
                    begin
                        next_state.ratio_sel = 1'b1;
                    end
                end
            end
        end

        // ------------------------------------------------------------
        // Reference divider on reference edges
        // ------------------------------------------------------------
        if (ref_edge)
        begin
            next_state.ref_divd = 1'b0;
            // Terminal count: reload and mark the divided output
            if (state.ref_cnt <= REF_W'(1))
            begin
                next_state.ref_cnt  = state.ref_div;
                next_state.ref_divd = 1'b1;
                ref_evt             = 1'b1;
            end
            else
            begin
                next_state.ref_cnt = state.ref_cnt - REF_W'(1);
            end
        end

        // ------------------------------------------------------------
        // Phase/frequency detector with minimum joint pulse
        // ------------------------------------------------------------
        // Both flags set: hold them for the joint time, then clear
        if (state.up && state.dn)
        begin
            if (state.clr_cnt >= PFD_CNT_W'(MIN_JOINT_CYC - 1))
            begin
                next_state.up      = 1'b0;
                next_state.dn      = 1'b0;
                next_state.clr_cnt = '0;
            end
            else
            begin
                next_state.clr_cnt = state.clr_cnt + PFD_CNT_W'(1);
            end
        end
        // Set wins over the clear
        if (ref_evt)
        begin
            next_state.up = 1'b1;
        end
        if (fb_evt)
        begin
            next_state.dn = 1'b1;
        end

        // ------------------------------------------------------------
        // Registered detector and lock outputs
        // ------------------------------------------------------------
        next_state.fb_lead_n  = !state.dn;
        next_state.ref_lead_n = !state.up;
        next_state.pd_out     = state.up && !state.dn;
        next_state.pd_oe_n    = !(state.up ^ state.dn);
        next_state.lock       = !(state.up ^ state.dn);

        // ------------------------------------------------------------
        // Synchronous reset
        // ------------------------------------------------------------
        if (SRST)
        begin
            // Counters, latches and detector flags start cleared
            next_state            = '0;
            next_state.pd_oe_n    = 1'b1;
            next_state.fb_lead_n  = 1'b1;
            next_state.ref_lead_n = 1'b1;
            next_state.lock       = 1'b1;
            // Pin stages keep filling, so release shows no false edge
            next_state.ref_s1     = REF_OSC_IN;
            next_state.ref_s2     = state.ref_s1;
            next_state.ref_s3     = state.ref_s2;
            next_state.vco_s1     = VCO_FEEDBACK_IN;
            next_state.vco_s2     = state.vco_s1;
            next_state.vco_s3     = state.vco_s2;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        state <= next_state;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PRESCALER_RATIO_SELECT = state.ratio_sel;
    assign FEEDBACK_DIVIDED_OUT   = state.fb_div;
    assign REF_DIVIDED_OUT        = state.ref_divd;
    assign TRISTATE_ERROR_OUT     = state.pd_out;
    assign TRISTATE_ERROR_OE_N    = state.pd_oe_n;
    assign FEEDBACK_LEAD_PULSE_N  = state.fb_lead_n;
    assign REF_LEAD_PULSE_N       = state.ref_lead_n;
    assign LOCK_INDICATOR         = state.lock;

endmodule

// file: dmp_core_properties.sv
// Port assertions for the divider core
`timescale 1ns/1ps
module dmp_core_properties
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic REF_OSC_IN,
    input wire logic VCO_FEEDBACK_IN,
    input wire logic PRESCALER_RATIO_SELECT,
    input wire logic FEEDBACK_DIVIDED_OUT,
    input wire logic REF_DIVIDED_OUT,
    input wire logic TRISTATE_ERROR_OUT,
    input wire logic TRISTATE_ERROR_OE_N,
    input wire logic FEEDBACK_LEAD_PULSE_N,
    input wire logic REF_LEAD_PULSE_N,
    input wire logic LOCK_INDICATOR
);
    logic [3:0] vco_age = 4'hf;
    logic [3:0] ref_age = 4'hf;
    logic       vco_q   = 1'b1;
    logic       ref_q   = 1'b1;
    always @(posedge CLOCK)
    begin
        vco_q   <= VCO_FEEDBACK_IN;
        ref_q   <= REF_OSC_IN;
        vco_age <= (VCO_FEEDBACK_IN && !vco_q) ? 4'h0 : vco_age + {3'h0, vco_age != 4'hf};
        ref_age <= (REF_OSC_IN && !ref_q) ? 4'h0 : ref_age + {3'h0, ref_age != 4'hf};
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    sequence s_both_low;
        !FEEDBACK_LEAD_PULSE_N && !REF_LEAD_PULSE_N;
    endsequence
    sequence s_one_low;
        FEEDBACK_LEAD_PULSE_N != REF_LEAD_PULSE_N;
    endsequence
    chk_drive_one_low: assert property (!TRISTATE_ERROR_OE_N |-> s_one_low)
        else $error("error output driven without single lead");
    chk_pd_polarity: assert property (!TRISTATE_ERROR_OE_N |->
        TRISTATE_ERROR_OUT == FEEDBACK_LEAD_PULSE_N) else $error("error output polarity");
    chk_lock_follows: assert property (s_one_low |->
        !LOCK_INDICATOR && !TRISTATE_ERROR_OE_N) else $error("single lead not flagged");
    chk_lock_high: assert property (FEEDBACK_LEAD_PULSE_N == REF_LEAD_PULSE_N |->
        LOCK_INDICATOR && TRISTATE_ERROR_OE_N) else $error("lock or float missing");
    chk_joint_brief: assert property (s_both_low ##1 s_both_low |=>
        !(!FEEDBACK_LEAD_PULSE_N && !REF_LEAD_PULSE_N)) else $error("joint pulse too long");
    chk_ratio_reload: assert property ($fell(PRESCALER_RATIO_SELECT) |->
        $rose(FEEDBACK_DIVIDED_OUT)) else $error("ratio fell without reload");
    chk_fb_timing: assert property ($changed(PRESCALER_RATIO_SELECT) ||
        $changed(FEEDBACK_DIVIDED_OUT) |-> vco_age inside {[2:7]}) else $error("fb out late");
    chk_ref_timing: assert property ($changed(REF_DIVIDED_OUT) |->
        ref_age inside {[2:7]}) else $error("ref out late");
    chk_ref_width: assert property ($rose(REF_DIVIDED_OUT) |=> REF_DIVIDED_OUT[*3])
        else $error("ref pulse short");
endmodule
bind dmp_core dmp_core_properties dmp_core_properties_inst (.CLOCK(CLOCK), .SRST(SRST),
    .REF_OSC_IN(REF_OSC_IN), .VCO_FEEDBACK_IN(VCO_FEEDBACK_IN),
    .PRESCALER_RATIO_SELECT(PRESCALER_RATIO_SELECT), .FEEDBACK_DIVIDED_OUT(FEEDBACK_DIVIDED_OUT),
    .REF_DIVIDED_OUT(REF_DIVIDED_OUT), .TRISTATE_ERROR_OUT(TRISTATE_ERROR_OUT),
    .TRISTATE_ERROR_OE_N(TRISTATE_ERROR_OE_N), .FEEDBACK_LEAD_PULSE_N(FEEDBACK_LEAD_PULSE_N),
    .REF_LEAD_PULSE_N(REF_LEAD_PULSE_N), .LOCK_INDICATOR(LOCK_INDICATOR));

// file: dmp_prescaler.sv
// Dual-modulus prescaler model driving the feedback pin
`timescale 1ns/1ps
module dmp_prescaler
#(
    parameter int P = 4
)
(
    input  wire logic clock,
    input  wire logic ratio_select,
    output logic      prescaled_out
);
    int count = 0;
    int half  = P + 1;
    assign prescaled_out = count < half;
    always @(posedge clock)
    begin
        count <= (count == 2 * half - 1) ? 0 : count + 1;
        if (count == 2 * half - 1)
            half <= ratio_select ? P : P + 1;
    end
endmodule

// file: dmp_core_tb.sv
// Self-checking bench for the divider core
`timescale 1ns/1ps
module dmp_core_tb
    import dmp_pkg::*;
;
    localparam int PRE_P = 4;
    logic       clock = 1'b0;
    logic       srst  = 1'b1;
    logic [3:0] bus_nibble = 4'h0;
    logic [2:0] latch_select = 3'h0;
    logic       load_strobe = 1'b0;
    logic       ref_osc_in = 1'b0;
    logic       vco_in, ratio, fb_div, ref_div, pd_out, pd_oe_n, fb_lead_n, ref_lead_n, lock;
    int         fails = 0, n_compared = 0, cycles = 0, ref_cnt = 0;
    int         r, n, a, t, fb_alone, ref_alone, low_lock;
    dmp_core dmp_core_inst (.CLOCK(clock), .SRST(srst), .BUS_NIBBLE(bus_nibble),
        .LATCH_SELECT(latch_select), .LOAD_STROBE(load_strobe), .REF_OSC_IN(ref_osc_in),
        .VCO_FEEDBACK_IN(vco_in), .PRESCALER_RATIO_SELECT(ratio), .FEEDBACK_DIVIDED_OUT(fb_div),
        .REF_DIVIDED_OUT(ref_div), .TRISTATE_ERROR_OUT(pd_out), .TRISTATE_ERROR_OE_N(pd_oe_n),
        .FEEDBACK_LEAD_PULSE_N(fb_lead_n), .REF_LEAD_PULSE_N(ref_lead_n), .LOCK_INDICATOR(lock));
    dmp_prescaler #(.P(PRE_P)) dmp_prescaler_inst (.clock(clock), .ratio_select(ratio),
        .prescaled_out(vco_in));
    always #5 clock = ~clock;
    always @(negedge clock)
    begin
        ref_cnt <= (ref_cnt + 1) % 4;
        if (ref_cnt == 3)
            ref_osc_in <= ~ref_osc_in;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            final_report();
        end
    end
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t expected %h got %h", $time, exp, got);
        end
    endtask
    function automatic logic [3:0] nib_of(input int s, input logic [11:0] rv,
                                          input logic [9:0] nv, input logic [6:0] av);
        logic [31:0] w;
        w = {rv, 2'h0, nv, 1'h0, av};
        return w[4*s +: 4];
    endfunction
    task automatic write_latch(input logic [2:0] sel, input logic [3:0] nib);
        @(negedge clock);
        latch_select = sel;
        bus_nibble = nib;
        @(negedge clock);
        load_strobe = 1'b1;
        repeat (3) @(negedge clock);
        load_strobe = 1'b0;
    endtask
    task automatic measure(input bit use_ref, output int cnt);
        logic prev, cur;
        cnt = 0;
        cur = 1'b1;
        prev = 1'b1;
        while (!(cur && !prev) && cnt < 2000)
        begin
            @(negedge clock);
            prev = cur;
            cur = use_ref ? ref_div : fb_div;
            cnt++;
        end
    endtask
    initial
    begin
        void'($urandom(32'he42e8bcd));
        repeat (4) @(negedge clock);
        srst = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            r = (k == 0) ? 4 : 4 + $urandom % 7;
            n = (k % 2 == 0) ? r - 1 : r + 1;
            a = (k == 0) ? 3 : $urandom % 4;
            // Main latches first: a cleared main count never meets a new aux count
            for (int s = 2; s < 10; s++)
                write_latch(s[2:0], nib_of(s % 8, r[11:0], n[9:0], a[6:0]));
            repeat (3) measure(0, t);
            check(2 * (PRE_P * n + a), t);
            repeat (2) measure(1, t);
            check(8 * r, t);
            // Detector start-up transient lasts up to 32 r squared cycles
            repeat (32 * r * r + 100) @(negedge clock);
            fb_alone = 0;
            ref_alone = 0;
            low_lock = 0;
            repeat (400)
            begin
                @(negedge clock);
                bus_nibble = 4'($urandom);
                latch_select = 3'($urandom);
                fb_alone += int'(!fb_lead_n && ref_lead_n);
                ref_alone += int'(fb_lead_n && !ref_lead_n);
                low_lock += int'(!lock);
            end
            check(0, (k % 2 == 0) ? ref_alone : fb_alone);
            check(1, ((k % 2 == 0) ? fb_alone : ref_alone) != 0);
            check(1, low_lock != 0);
            repeat (2) measure(0, t);
            check(2 * (PRE_P * n + a), t);
            $display("test %0d done r=%0d n=%0d a=%0d", k, r, n, a);
        end
        final_report();
    end
endmodule
